//--- design/adcsi_pkg.sv
package adcsi_pkg;

  // Converter word
  localparam int CODE_W = 11;
  localparam int CODE_COUNT = 2048;
  localparam int LEVEL_W = 12;
  localparam int COARSE_W = 5;
  localparam int FINE_W = 6;
  localparam logic [CODE_W-1:0] CODE_MAX = 11'h07FF;
  localparam logic [LEVEL_W-1:0] OVERFLOW_LEVEL = 12'h0800;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int APERTURE_DELAY_NS = 50;
  localparam int APERTURE_CYC_RAW = APERTURE_DELAY_NS / CLK_PERIOD_NS;
  localparam int APERTURE_CYC = (APERTURE_CYC_RAW < 1) ? 1 : APERTURE_CYC_RAW;
  localparam int LATENCY_PERIODS = 2;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] RESULT_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET = 4'hC;
  localparam int EVT_READY_BIT = 0;
  localparam int EVT_OVERFLOW_BIT = 1;
  localparam int EVT_W = 2;
  localparam int RESULT_OVF_BIT = 11;
  localparam logic [EVT_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;
  localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic overflow;
    logic [CODE_W-1:0] code;
  } adcsi_result_type;

  localparam adcsi_result_type RESULT_RESET = '{overflow: 1'b0, code: 11'h000};

  // Ideal transfer: clamp to the top code, flag at or above the top step
  function automatic adcsi_result_type adcsi_convert(
    input logic [LEVEL_W-1:0] level
  );
    adcsi_result_type r;
    r.overflow = (level >= OVERFLOW_LEVEL);
    r.code = (level > {1'b0, CODE_MAX}) ? CODE_MAX : level[CODE_W-1:0];
    return r;
  endfunction : adcsi_convert

endpackage : adcsi_pkg

//--- design/adcsi_sync.sv
`timescale 1ns/100ps
`default_nettype none

module adcsi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : adcsi_sync

`default_nettype wire

//--- design/adcsi_two_step.sv
`timescale 1ns/100ps
`default_nettype none

module adcsi_two_step
  import adcsi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Phase events
  input wire logic sample_evt,
  input wire logic balance_evt,
  input wire logic [LEVEL_W-1:0] level,
  // Encoded word
  output var adcsi_result_type result
);

  adcsi_result_type held_reg;
  adcsi_result_type conv;
  logic [COARSE_W-1:0] coarse_reg;

  assign conv = adcsi_convert(level);

  // Coarse pass picks the range at the end of sampling
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      held_reg <= RESULT_RESET;
      coarse_reg <= '0;
    end else if (sample_evt) begin
      held_reg <= conv;
      coarse_reg <= conv.code[CODE_W-1:FINE_W];
    end
  end

  // Fine pass completes the low bits in the balance phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result <= RESULT_RESET;
    end else if (balance_evt) begin
      result.code <= {coarse_reg, held_reg.code[FINE_W-1:0]};
      result.overflow <= held_reg.overflow;
    end
  end

endmodule : adcsi_two_step

`default_nettype wire

//--- design/adcsi_top.sv
// Overview of operation
// - Each sample becomes one of 2048 codes on an 11-bit word, bit 10 MSB.
// - Conversion follows the converter clock; results appear two periods on.
// - With the phase control low, sampling ends at the rising clock edge.
// - Encoded codes pass two D-type stages, so the word holds between updates.
// - Overflow is a separate flag at or above the top step; data clamps to the top code.
// - Chip enable low floats both; high drives overflow, data if enable_n low.
// - Coarse stage sets the upper bits; the fine stage ends in the balance.
// - Unconnected phase and data enable read low, chip enable reads high.
`timescale 1ns/100ps
`default_nettype none

module adcsi_top
  import adcsi_pkg::*;
(
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // Converter pins
  input wire logic conv_clk,
  input wire logic sample_phase,
  input wire logic data_bus_enable_n,
  input wire logic chip_output_enable,
  input wire logic [LEVEL_W-1:0] analog_level,
  // Output buffers
  output logic [CODE_W-1:0] conversion_code,
  output logic conversion_code_oe,
  output logic overflow_flag,
  output logic overflow_flag_oe,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Interrupt
  output logic irq
);

  logic conv_clk_s;
  logic phase_s;
  logic data_en_n_s;
  logic chip_en_s;
  logic [LEVEL_W-1:0] level_s;
  logic conv_clk_prev_reg;
  logic rise;
  logic fall;
  logic [APERTURE_CYC-1:0] sample_dly_reg;
  logic [APERTURE_CYC-1:0] balance_dly_reg;
  logic sample_evt;
  logic balance_evt;
  adcsi_result_type encoded;
  adcsi_result_type stage1_reg;
  adcsi_result_type stage2_reg;
  logic [1:0] fill_reg;
  logic ready_evt;
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] status_next;
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] events;
  logic [DATA_W-1:0] count_reg;

  // Pins cross in through two flops each
  adcsi_sync #(.WIDTH(4)) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({conv_clk, sample_phase, data_bus_enable_n, chip_output_enable}),
    .sync_out({conv_clk_s, phase_s, data_en_n_s, chip_en_s})
  );

  adcsi_sync #(.WIDTH(LEVEL_W)) u_level_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(analog_level),
    .sync_out(level_s)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conv_clk_prev_reg <= 1'b0;
    end else begin
      conv_clk_prev_reg <= conv_clk_s;
    end
  end

  assign rise = conv_clk_s & ~conv_clk_prev_reg;
  assign fall = ~conv_clk_s & conv_clk_prev_reg;

  // Sampling edge chosen by phase; the other edge opens the balance phase.
  // Only edges count, so a stopped clock simply parks the converter.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sample_dly_reg <= '0;
      balance_dly_reg <= '0;
    end else begin
      // Cast keeps the newest bits; the oldest falls off the end
      sample_dly_reg <= APERTURE_CYC'({sample_dly_reg,
                                       phase_s ? fall : rise});
      balance_dly_reg <= APERTURE_CYC'({balance_dly_reg,
                                        phase_s ? rise : fall});
    end
  end

  // Aperture delay: the level is taken a fixed time after the edge
  assign sample_evt = sample_dly_reg[APERTURE_CYC-1];
  assign balance_evt = balance_dly_reg[APERTURE_CYC-1];

  adcsi_two_step u_two_step (
    .mclk(mclk),
    .rst_n(rst_n),
    .sample_evt(sample_evt),
    .balance_evt(balance_evt),
    .level(level_s),
    .result(encoded)
  );

  // Two D stages clocked by the sampling edge: two periods of latency
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1_reg <= RESULT_RESET;
      stage2_reg <= RESULT_RESET;
      fill_reg <= 2'h0;
    end else if (sample_evt) begin
      stage1_reg <= encoded;
      stage2_reg <= stage1_reg;
      fill_reg <= {fill_reg[0], 1'b1};
    end
  end

  assign ready_evt = sample_evt & fill_reg[1];

  // Outputs follow the second stage; enables mirror the pin logic.
  // Pins cross through synchronisers, so enables lag by three mclk edges.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      conversion_code <= '0;
      overflow_flag <= 1'b0;
      conversion_code_oe <= 1'b0;
      overflow_flag_oe <= 1'b0;
    end else begin
      conversion_code <= stage2_reg.code;
      overflow_flag <= stage2_reg.overflow;
      conversion_code_oe <= chip_en_s & ~data_en_n_s;
      overflow_flag_oe <= chip_en_s;
    end
  end

  // Sticky events; a new event wins over a write-one clear
  assign events[EVT_READY_BIT] = ready_evt;
  assign events[EVT_OVERFLOW_BIT] = ready_evt & stage1_reg.overflow;

  always_comb begin
    status_next = status_reg;
    if (reg_wr && reg_addr == STATUS_OFFSET) begin
      status_next = status_next & ~reg_wdata[EVT_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_reg <= MASK_RESET;
    end else if (reg_wr && reg_addr == MASK_OFFSET) begin
      mask_reg <= reg_wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_reg <= COUNT_RESET;
    end else if (ready_evt) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_reg);
    end
  end

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        STATUS_OFFSET: reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, status_reg};
        MASK_OFFSET: reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, mask_reg};
        RESULT_OFFSET: reg_rdata <= {4'h0, stage2_reg.overflow,
                                     stage2_reg.code};
        COUNT_OFFSET: reg_rdata <= count_reg;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : adcsi_top

`default_nettype wire

//--- tb/adcsi_props.sv
`timescale 1ns/100ps
`default_nettype none
module adcsi_props
  import adcsi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins
  input wire logic data_bus_enable_n,
  input wire logic chip_output_enable,
  input wire logic [CODE_W-1:0] conversion_code,
  input wire logic conversion_code_oe,
  input wire logic overflow_flag,
  input wire logic overflow_flag_oe,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Synchronisers restart at reset, so skip the first edges after it
  a_ovf_oe_follow: assert property (
    $past(rst_n, 4) && $past(rst_n, 2) |->
    overflow_flag_oe == $past(chip_output_enable, 3))
    else $error("overflow enable wrong");
  a_data_oe_off: assert property (
    $past(rst_n, 4) && $past(rst_n, 2) && $past(data_bus_enable_n, 3)
    |-> !conversion_code_oe)
    else $error("data driven while disabled");
  a_data_oe_chip: assert property (
    conversion_code_oe |-> overflow_flag_oe)
    else $error("data driven without chip enable");
  a_code_hold: assert property (
    $changed(conversion_code) |=> $stable(conversion_code) [*8])
    else $error("code not held");
  a_ovf_clamp: assert property (
    overflow_flag |-> conversion_code == CODE_MAX)
    else $error("overflow without top code");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read");
  a_rd_unmapped: assert property (
    $past(reg_rd) && ($past(reg_addr) & 4'h3) != 4'h0 |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  // A mask write lowers irq one cycle late, so skip the cycle after it
  a_irq_sticky: assert property (
    irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("irq dropped without write");
endmodule : adcsi_props
bind adcsi_top adcsi_props u_adcsi_props (.*);
`default_nettype wire

//--- tb/adcsi_host.sv
`timescale 1ns/100ps
`default_nettype none
module adcsi_host (
  // Clock
  input wire logic mclk,
  // Converter clock
  output logic conv_clk
);
  initial conv_clk = 1'b0;
  // Burst clocking: the clock rests low between conversions
  task automatic pulse();
    repeat (6) @(posedge mclk);
    conv_clk <= 1'b1;
    repeat (6) @(posedge mclk);
    conv_clk <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : pulse
endmodule : adcsi_host
`default_nettype wire

//--- tb/adcsi_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcsi_tb_top;
  import adcsi_pkg::*;
  logic mclk = 0, rst_n = 0, ph = 0, den = 0, ce = 1, rel = 0;
  logic reg_wr = 0, reg_rd = 0, conv_clk, conversion_code_oe;
  logic overflow_flag, overflow_flag_oe, irq;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [LEVEL_W-1:0] analog_level = '0;
  logic [CODE_W-1:0] conversion_code;
  wire sample_phase, data_bus_enable_n, chip_output_enable;
  int bad_count = 0, n_tests = 0, cyc = 0, ovs, last;
  int lv[$];
  int bnd[4] = '{2047, 2048, 0, 4095};
  pulldown (sample_phase);
  pulldown (data_bus_enable_n);
  pullup (chip_output_enable);
  // A released pin settles to its resistor level
  assign sample_phase = rel ? 1'bz : ph;
  assign data_bus_enable_n = rel ? 1'bz : den;
  assign chip_output_enable = rel ? 1'bz : ce;
  always #50 mclk = ~mclk;
  adcsi_top u_adcsi_top (.*);
  adcsi_host u_adcsi_host (.mclk, .conv_clk);
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [DATA_W-1:0] s, input int e);
    n_tests++;
    if (s !== e[DATA_W-1:0]) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input int d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d[DATA_W-1:0];
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    @(posedge mclk);
    #1;
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input int e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 check(reg_rdata, e);
  endtask : rdc
  // p is the phase expected to act, drv what the bench drives on the pin
  task automatic run(input logic p, input logic drv);
    int l;
    if ($time > 0) @(posedge mclk);
    rst_n <= 0;
    ph <= drv;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    ovs = 0;
    lv = {};
    rdc(STATUS_OFFSET, 0);
    rdc(MASK_OFFSET, 0);
    rdc(COUNT_OFFSET, 0);
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      l = (i < 4) ? bnd[i] : $urandom_range(4095);
      lv.push_back(l);
      // The wrong edge sees the inverted level, so a phase mix-up shows
      fork
        u_adcsi_host.pulse();
        begin
          analog_level <= p ? ~l[LEVEL_W-1:0] : l[LEVEL_W-1:0];
          repeat (9) @(posedge mclk);
          analog_level <= p ? l[LEVEL_W-1:0] : ~l[LEVEL_W-1:0];
        end
      join
      if (i >= 2) begin
        l = lv.pop_front();
        last = (l > 2047) ? 2047 : l;
        ovs |= (l >= 2048);
        check(conversion_code, last);
        check(overflow_flag, l >= 2048);
        last |= int'(l >= 2048) << RESULT_OVF_BIT;
      end
    end
  endtask : run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(45947));
    run(0, 0);
    rdc(COUNT_OFFSET, 6);
    rdc(RESULT_OFFSET, last);
    wr(RESULT_OFFSET, 16'hFFFF);
    rdc(RESULT_OFFSET, last);
    rdc(4'h2, 0);
    rdc(STATUS_OFFSET, 1 | (ovs << 1));
    check(irq, 0);
    wr(MASK_OFFSET, 1);
    check(irq, 1);
    wr(STATUS_OFFSET, 3);
    check(irq, 0);
    rdc(STATUS_OFFSET, 0);
    run(1, 1);
    for (int k = 0; k < 5; k++) begin
      den <= k[0];
      ce <= k[1];
      rel <= k[2];
      repeat (5) @(posedge mclk);
      #1 check(overflow_flag_oe, k[1] | k[2]);
      check(conversion_code_oe, (k[1] & ~k[0]) | k[2]);
    end
    // Phase pin still released: the pull-down must select the rising edge
    run(0, 1);
    conclude();
  end
endmodule : adcsi_tb_top
`default_nettype wire
